// ==== pkg/aad_pkg.sv ====
package aad_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int NIB_W  = 4;

  // ---------------------------------------------------------------
  // Flag byte layout
  // ---------------------------------------------------------------
  localparam int FLAG_S  = 7;
  localparam int FLAG_Z  = 6;
  localparam int FLAG_H  = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N  = 1;
  localparam int FLAG_C  = 0;

  // ---------------------------------------------------------------
  // Byte register slots, indexed by the register select code
  // ---------------------------------------------------------------
  localparam logic [2:0] SLOT_B   = 3'h0;
  localparam logic [2:0] SLOT_C   = 3'h1;
  localparam logic [2:0] SLOT_D   = 3'h2;
  localparam logic [2:0] SLOT_E   = 3'h3;
  localparam logic [2:0] SLOT_PH  = 3'h4;
  localparam logic [2:0] SLOT_PL  = 3'h5;
  localparam logic [2:0] SLOT_F   = 3'h6;
  localparam logic [2:0] SLOT_ACC = 3'h7;
  localparam logic [2:0] RSEL_MEM = 3'h6;

  // ---------------------------------------------------------------
  // Pair select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] PAIR_FIRST  = 2'h0;
  localparam logic [1:0] PAIR_SECOND = 2'h1;
  localparam logic [1:0] PAIR_SELF   = 2'h2;
  localparam logic [1:0] PAIR_STACK  = 2'h3;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_PFX_IDX1 = 8'hDD;
  localparam logic [7:0] OPC_PFX_IDX2 = 8'hFD;
  localparam logic [7:0] OPC_PFX_EXT  = 8'hED;
  localparam logic [7:0] OPC_ADD_IMM  = 8'hC6;
  localparam logic [7:0] OPC_ADC_IMM  = 8'hCE;
  localparam logic [3:0] OPC_ALU8_HI  = 4'h8;
  localparam logic [1:0] OPC_ADD16_HI = 2'h0;
  localparam logic [1:0] OPC_ADC16_HI = 2'h1;
  localparam logic [3:0] OPC_ADD16_LO = 4'h9;
  localparam logic [3:0] OPC_ADC16_LO = 4'hA;

  // ---------------------------------------------------------------
  // Instruction lengths
  // ---------------------------------------------------------------
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // ---------------------------------------------------------------
  // Register port map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADR_IDX1_HI = 4'h8;
  localparam logic [3:0] ADR_IDX1_LO = 4'h9;
  localparam logic [3:0] ADR_IDX2_HI = 4'hA;
  localparam logic [3:0] ADR_IDX2_LO = 4'hB;
  localparam logic [3:0] ADR_SP_HI   = 4'hC;
  localparam logic [3:0] ADR_SP_LO   = 4'hD;
  localparam logic [3:0] ADR_STATUS  = 4'hE;
  localparam int STAT_BUSY = 0;
  localparam int STAT_BAD  = 1;
  localparam int STAT_LEN  = 4;

  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [2:0] {
    S_OP, S_PFX, S_IMM, S_DISP, S_MEM, S_EXEC
  } aad_state_t;
  typedef enum logic [1:0] {K_ADD8, K_ADC8, K_ADD16, K_ADC16} aad_kind_t;
  typedef enum logic [1:0] {D_PTR, D_IDX1, D_IDX2} aad_dst_t;

endpackage : aad_pkg

// ==== core/aad_adder.sv ====
`timescale 1ns/100ps
module aad_adder
  import aad_pkg::*;
#(
  parameter int W = BYTE_W
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  output logic      [W-1:0] sum,
  output logic              half,
  output logic              carry,
  output logic              ovf
);

  localparam int HALF_BIT = W - NIB_W;
  logic [W:0] full;

  assign full  = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
  assign sum   = full[W-1:0];
  assign carry = full[W];
  // Carry into the top nibble is the carry out of the nibble below it.
  assign half  = a[HALF_BIT] ^ b[HALF_BIT] ^ full[HALF_BIT];
  assign ovf   = (a[W-1] == b[W-1]) && (full[W-1] != a[W-1]); // [RULE_14]

  property p_ovf_sign;
    @(posedge clk) disable iff (reset)
    ovf |-> (a[W-1] == b[W-1]) && (sum[W-1] == ~b[W-1]);
  endproperty
  a_ovf_sign: assert property (p_ovf_sign) // [RULE_14]
    else $error("overflow set without sign change");

endmodule : aad_adder

// ==== core/aad_decode.sv ====
`timescale 1ns/100ps
module aad_decode
  import aad_pkg::*;
(
  input  wire logic [7:0] op,
  output logic            alu8,
  output logic            use_cy,
  output logic [2:0]      rsel,
  output logic            imm8,
  output logic            add16,
  output logic            adc16,
  output logic [1:0]      pair,
  output logic            pfx_idx1,
  output logic            pfx_idx2,
  output logic            pfx_ext
);

  // Bit 3 separates the carry-using add from the plain add.
  assign alu8     = op[7:4] == OPC_ALU8_HI; // [RULE_06]
  assign use_cy   = op[3]; // [RULE_06]
  assign rsel     = op[2:0]; // [RULE_05]
  assign imm8     = (op == OPC_ADD_IMM) || (op == OPC_ADC_IMM);
  assign add16    = (op[7:6] == OPC_ADD16_HI) && (op[3:0] == OPC_ADD16_LO);
  assign adc16    = (op[7:6] == OPC_ADC16_HI) && (op[3:0] == OPC_ADC16_LO);
  assign pair     = op[5:4]; // [RULE_09]
  assign pfx_idx1 = op == OPC_PFX_IDX1;
  assign pfx_idx2 = op == OPC_PFX_IDX2;
  assign pfx_ext  = op == OPC_PFX_EXT;

endmodule : aad_decode

// ==== core/aad_datapath.sv ====
// How it works
// (RULE_01) Add with carry adds the byte operand and carry to the accumulator.
// (RULE_02) Plain add adds the byte operand to the accumulator, no carry in.
// (RULE_03) Indexed forms read memory at index plus displacement, 3 bytes.
// (RULE_04) Register and pointer-memory forms take 1 byte, immediate takes 2.
// (RULE_05) Select codes 000-101 name six byte registers, 111 the acc.
// (RULE_06) Opcode 10001rrr is add with carry, 10000rrr is plain add.
// (RULE_07) Byte adds set S, Z, H from bit 3, V, clear N, C from bit 7.
// (RULE_08) Prefixed 16-bit add with carry adds pair and carry to the pointer.
// (RULE_09) Pair code 00, 01, 10, 11 picks first, second, self, stack pointer.
// (RULE_10) Word add with carry sets S, Z, H from bit 11, V, N clear, C.
// (RULE_11) One-byte pointer add keeps S, Z, V, sets H, clears N.
// (RULE_12) Two-byte index add sums the pair into the index register.
// (RULE_13) Index add keeps S, Z, V, clears N, H from 11 and C from 15.
// (RULE_14) Overflow is same-sign addends giving an opposite-sign result.
// (RULE_15) Plain pointer add takes carry from the top of the 16-bit sum.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module aad_datapath
  import aad_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ins_valid,
  input  wire logic [7:0]        ins_byte,
  output logic                   ins_ready,
  output logic                   mem_req,
  output logic [WORD_W-1:0]      mem_addr,
  input  wire logic              mem_ack,
  input  wire logic [7:0]        mem_rdata,
  output logic                   done,
  output logic [1:0]             done_len,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [7:0]        bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic [7:0]             bus_rdata
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  aad_state_t        state_r, state_nxt;
  aad_kind_t         kind_r, kind_nxt;
  aad_dst_t          dst_r, dst_nxt;
  logic              ext_r, ext_nxt;
  logic [1:0]        pair_r, pair_nxt;
  logic [7:0]        opnd_r, opnd_nxt;
  logic [1:0]        len_r, len_nxt;
  logic              mreq_r, mreq_nxt;
  logic [WORD_W-1:0] maddr_r, maddr_nxt;
  logic              rdy_r, rdy_nxt;
  logic              bad_r, bad_nxt;
  logic [7:0]        gpr_r [8];
  logic [7:0]        gpr_nxt [8];
  logic [WORD_W-1:0] idx1_r, idx1_nxt;
  logic [WORD_W-1:0] idx2_r, idx2_nxt;
  logic [WORD_W-1:0] sp_r, sp_nxt;
  logic              done_r, done_nxt;
  logic [1:0]        dlen_r, dlen_nxt;
  logic [7:0]        rdata_r, rdata_nxt;

  logic              take;
  logic              dc_alu8, dc_cy, dc_imm, dc_add16, dc_adc16;
  logic              dc_pidx1, dc_pidx2, dc_pext;
  logic [2:0]        dc_rsel;
  logic [1:0]        dc_pair;
  logic [WORD_W-1:0] ptr_pair, first_pair, second_pair;
  logic [WORD_W-1:0] dst_val, pair_val, idx_val, disp_addr;
  logic [7:0]        s8;
  logic              h8, c8, v8;
  logic [WORD_W-1:0] s16;
  logic              h16, c16, v16;
  logic              cy_in, is8, cy8_en, cy16_en;

  assign take        = ins_valid && rdy_r;
  assign ptr_pair    = {gpr_r[SLOT_PH], gpr_r[SLOT_PL]};
  assign first_pair  = {gpr_r[SLOT_B], gpr_r[SLOT_C]};
  assign second_pair = {gpr_r[SLOT_D], gpr_r[SLOT_E]};
  assign cy_in       = gpr_r[SLOT_F][FLAG_C];
  assign is8         = (kind_r == K_ADD8) || (kind_r == K_ADC8);
  assign cy8_en      = (kind_r == K_ADC8) && cy_in; // [RULE_01] [RULE_02]
  assign cy16_en     = (kind_r == K_ADC16) && cy_in; // [RULE_08]
  assign idx_val     = (dst_r == D_IDX2) ? idx2_r : idx1_r;
  assign disp_addr   = idx_val + {{BYTE_W{ins_byte[7]}}, ins_byte}; // [RULE_03]

  // ---------------------------------------------------------------
  // Operand selection
  // ---------------------------------------------------------------
  always_comb begin
    unique case (dst_r)
      D_IDX1:  dst_val = idx1_r;
      D_IDX2:  dst_val = idx2_r;
      default: dst_val = ptr_pair;
    endcase
    unique case (pair_r) // [RULE_09] [RULE_12]
      PAIR_FIRST:  pair_val = first_pair;
      PAIR_SECOND: pair_val = second_pair;
      PAIR_SELF:   pair_val = dst_val;
      default:     pair_val = sp_r;
    endcase
  end

  aad_decode u_dec (
    .op       (ins_byte),
    .alu8     (dc_alu8),
    .use_cy   (dc_cy),
    .rsel     (dc_rsel),
    .imm8     (dc_imm),
    .add16    (dc_add16),
    .adc16    (dc_adc16),
    .pair     (dc_pair),
    .pfx_idx1 (dc_pidx1),
    .pfx_idx2 (dc_pidx2),
    .pfx_ext  (dc_pext)
  );

  aad_adder #(.W(BYTE_W)) u_add8 (
    .clk   (clk),
    .reset (reset),
    .a     (gpr_r[SLOT_ACC]),
    .b     (opnd_r),
    .cin   (cy8_en),
    .sum   (s8),
    .half  (h8),
    .carry (c8),
    .ovf   (v8)
  );

  aad_adder #(.W(WORD_W)) u_add16 (
    .clk   (clk),
    .reset (reset),
    .a     (dst_val),
    .b     (pair_val),
    .cin   (cy16_en),
    .sum   (s16),
    .half  (h16),
    .carry (c16),
    .ovf   (v16)
  );

  // ---------------------------------------------------------------
  // Instruction sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    dst_nxt   = dst_r;
    ext_nxt   = ext_r;
    pair_nxt  = pair_r;
    opnd_nxt  = opnd_r;
    len_nxt   = len_r;
    mreq_nxt  = mreq_r;
    maddr_nxt = maddr_r;
    bad_nxt   = bad_r;
    if (bus_wr && bus_addr == ADR_STATUS) begin
      bad_nxt = 1'b0;
    end
    unique case (state_r)
      S_OP: if (take) begin
        len_nxt  = LEN_ONE; // [RULE_04]
        dst_nxt  = D_PTR;
        pair_nxt = dc_pair;
        kind_nxt = dc_cy ? K_ADC8 : K_ADD8; // [RULE_06]
        if (dc_alu8 && dc_rsel == RSEL_MEM) begin
          mreq_nxt  = 1'b1;
          maddr_nxt = ptr_pair;
          state_nxt = S_MEM;
        end else if (dc_alu8) begin
          opnd_nxt  = gpr_r[dc_rsel]; // [RULE_05]
          state_nxt = S_EXEC;
        end else if (dc_imm) begin
          len_nxt   = LEN_TWO; // [RULE_04]
          state_nxt = S_IMM;
        end else if (dc_add16) begin
          kind_nxt  = K_ADD16; // [RULE_11]
          state_nxt = S_EXEC;
        end else if (dc_pidx1 || dc_pidx2 || dc_pext) begin
          dst_nxt   = dc_pidx2 ? D_IDX2 : (dc_pidx1 ? D_IDX1 : D_PTR);
          ext_nxt   = dc_pext;
          state_nxt = S_PFX;
        end else begin
          bad_nxt = 1'b1;
        end
      end
      S_PFX: if (take) begin
        len_nxt   = LEN_TWO;
        pair_nxt  = dc_pair;
        kind_nxt  = dc_cy ? K_ADC8 : K_ADD8;
        state_nxt = S_EXEC;
        if (ext_r && dc_adc16) begin
          kind_nxt = K_ADC16; // [RULE_08]
        end else if (!ext_r && dc_alu8 && dc_rsel == RSEL_MEM) begin
          len_nxt   = LEN_THREE; // [RULE_03]
          state_nxt = S_DISP;
        end else if (!ext_r && dc_add16) begin
          kind_nxt = K_ADD16; // [RULE_12]
        end else begin
          bad_nxt   = 1'b1;
          state_nxt = S_OP;
        end
      end
      S_IMM: if (take) begin
        opnd_nxt  = ins_byte; // [RULE_04]
        state_nxt = S_EXEC;
      end
      S_DISP: if (take) begin
        mreq_nxt  = 1'b1;
        maddr_nxt = disp_addr; // [RULE_03]
        state_nxt = S_MEM;
      end
      S_MEM: if (mem_ack) begin
        opnd_nxt  = mem_rdata;
        mreq_nxt  = 1'b0;
        state_nxt = S_EXEC;
      end
      S_EXEC: state_nxt = S_OP;
    endcase
    rdy_nxt = (state_nxt == S_OP) || (state_nxt == S_PFX) ||
              (state_nxt == S_IMM) || (state_nxt == S_DISP);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= S_OP;
      kind_r  <= K_ADD8;
      dst_r   <= D_PTR;
      ext_r   <= 1'b0;
      pair_r  <= PAIR_FIRST;
      opnd_r  <= BYTE_RST;
      len_r   <= LEN_ONE;
      mreq_r  <= 1'b0;
      maddr_r <= WORD_RST;
      rdy_r   <= 1'b1;
      bad_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      dst_r   <= dst_nxt;
      ext_r   <= ext_nxt;
      pair_r  <= pair_nxt;
      opnd_r  <= opnd_nxt;
      len_r   <= len_nxt;
      mreq_r  <= mreq_nxt;
      maddr_r <= maddr_nxt;
      rdy_r   <= rdy_nxt;
      bad_r   <= bad_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Register file, write-back and register port
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] f;
    f         = gpr_r[SLOT_F];
    gpr_nxt   = gpr_r;
    idx1_nxt  = idx1_r;
    idx2_nxt  = idx2_r;
    sp_nxt    = sp_r;
    done_nxt  = 1'b0;
    dlen_nxt  = dlen_r;
    rdata_nxt = BYTE_RST;
    // The lower half of the map holds the byte slots by select code.
    if (bus_wr && !bus_addr[ADDR_W-1]) begin
      gpr_nxt[bus_addr[2:0]] = bus_wdata;
    end
    if (bus_wr) begin
      unique case (bus_addr)
        ADR_IDX1_HI: idx1_nxt[15:8] = bus_wdata;
        ADR_IDX1_LO: idx1_nxt[7:0]  = bus_wdata;
        ADR_IDX2_HI: idx2_nxt[15:8] = bus_wdata;
        ADR_IDX2_LO: idx2_nxt[7:0]  = bus_wdata;
        ADR_SP_HI:   sp_nxt[15:8]   = bus_wdata;
        ADR_SP_LO:   sp_nxt[7:0]    = bus_wdata;
        default:     ;
      endcase
    end
    if (bus_rd) begin
      unique case (bus_addr)
        ADR_IDX1_HI: rdata_nxt = idx1_r[15:8];
        ADR_IDX1_LO: rdata_nxt = idx1_r[7:0];
        ADR_IDX2_HI: rdata_nxt = idx2_r[15:8];
        ADR_IDX2_LO: rdata_nxt = idx2_r[7:0];
        ADR_SP_HI:   rdata_nxt = sp_r[15:8];
        ADR_SP_LO:   rdata_nxt = sp_r[7:0];
        ADR_STATUS: begin
          rdata_nxt[STAT_BUSY] = state_r != S_OP;
          rdata_nxt[STAT_BAD]  = bad_r;
          rdata_nxt[STAT_LEN+1:STAT_LEN] = dlen_r;
        end
        default:     rdata_nxt = bus_addr[ADDR_W-1] ? BYTE_RST
                                 : gpr_r[bus_addr[2:0]];
      endcase
    end
    // Write-back overrides a register port write in the same cycle.
    if (state_r == S_EXEC) begin
      done_nxt   = 1'b1;
      dlen_nxt   = len_r;
      f[FLAG_N]  = 1'b0; // [RULE_07] [RULE_10] [RULE_11] [RULE_13]
      if (is8) begin
        gpr_nxt[SLOT_ACC] = s8; // [RULE_01] [RULE_02]
        f[FLAG_S]  = s8[7]; // [RULE_07]
        f[FLAG_Z]  = s8 == BYTE_RST;
        f[FLAG_H]  = h8;
        f[FLAG_PV] = v8; // [RULE_14]
        f[FLAG_C]  = c8;
      end else begin
        f[FLAG_H] = h16; // [RULE_10] [RULE_11] [RULE_13]
        f[FLAG_C] = c16; // [RULE_15] [RULE_13]
        if (kind_r == K_ADC16) begin
          f[FLAG_S]  = s16[15]; // [RULE_10]
          f[FLAG_Z]  = s16 == WORD_RST;
          f[FLAG_PV] = v16;
        end
        unique case (dst_r)
          D_IDX1:  idx1_nxt = s16; // [RULE_12]
          D_IDX2:  idx2_nxt = s16;
          default: begin
            gpr_nxt[SLOT_PH] = s16[15:8]; // [RULE_08] [RULE_11]
            gpr_nxt[SLOT_PL] = s16[7:0];
          end
        endcase
      end
      gpr_nxt[SLOT_F] = f;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gpr_r   <= '{default: BYTE_RST};
      idx1_r  <= WORD_RST;
      idx2_r  <= WORD_RST;
      sp_r    <= WORD_RST;
      done_r  <= 1'b0;
      dlen_r  <= LEN_ONE;
      rdata_r <= BYTE_RST;
    end else begin
      gpr_r   <= gpr_nxt;
      idx1_r  <= idx1_nxt;
      idx2_r  <= idx2_nxt;
      sp_r    <= sp_nxt;
      done_r  <= done_nxt;
      dlen_r  <= dlen_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign ins_ready = rdy_r;
  assign mem_req   = mreq_r;
  assign mem_addr  = maddr_r;
  assign done      = done_r;
  assign done_len  = dlen_r;
  assign bus_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic ex8, ex16;
  assign ex8  = state_r == S_EXEC && is8 &&
                !(bus_wr && bus_addr == {1'b0, SLOT_ACC});
  assign ex16 = state_r == S_EXEC && !is8 && !bus_wr;

  property p_adc8;
    @(posedge clk) disable iff (reset)
    ex8 && kind_r == K_ADC8 |=> gpr_r[SLOT_ACC] ==
      8'($past(gpr_r[SLOT_ACC]) + $past(opnd_r) + $past(cy_in));
  endproperty
  a_adc8: assert property (p_adc8) else $error("adc byte sum wrong"); // [RULE_01]

  property p_add8;
    @(posedge clk) disable iff (reset)
    ex8 && kind_r == K_ADD8 |=> gpr_r[SLOT_ACC] ==
      8'($past(gpr_r[SLOT_ACC]) + $past(opnd_r));
  endproperty
  a_add8: assert property (p_add8) else $error("add byte sum wrong"); // [RULE_02]

  sequence s_disp_taken;
    state_r == S_DISP && take;
  endsequence
  property p_idx_addr;
    @(posedge clk) disable iff (reset)
    s_disp_taken |=> mem_req && mem_addr == $past(disp_addr) && len_r == LEN_THREE;
  endproperty
  a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong"); // [RULE_03]

  property p_len_reg;
    @(posedge clk) disable iff (reset)
    state_r == S_OP && take && dc_alu8 |-> ##1 len_r == LEN_ONE ##[1:300] done;
  endproperty
  a_len_reg: assert property (p_len_reg) else $error("short form length wrong"); // [RULE_04]

  property p_rsel;
    @(posedge clk) disable iff (reset)
    state_r == S_OP && take && dc_alu8 && dc_rsel != RSEL_MEM
      |=> state_r == S_EXEC && opnd_r == $past(gpr_r[dc_rsel]);
  endproperty
  a_rsel: assert property (p_rsel) else $error("register select wrong"); // [RULE_05]

  property p_opc;
    @(posedge clk) disable iff (reset)
    state_r == S_OP && take && ins_byte[7:3] == {OPC_ALU8_HI, 1'b1}
      |=> kind_r == K_ADC8;
  endproperty
  a_opc: assert property (p_opc) else $error("adc opcode decode wrong"); // [RULE_06]

  property p_flag8;
    @(posedge clk) disable iff (reset)
    ex8 && !(bus_wr && bus_addr == {1'b0, SLOT_F}) |=> !gpr_r[SLOT_F][FLAG_N] &&
      gpr_r[SLOT_F][FLAG_C] == $past(c8) && gpr_r[SLOT_F][FLAG_H] == $past(h8);
  endproperty
  a_flag8: assert property (p_flag8) else $error("byte flags wrong"); // [RULE_07]

  property p_adc16;
    @(posedge clk) disable iff (reset)
    ex16 && kind_r == K_ADC16 |=> ptr_pair == 16'($past(dst_val) +
      $past(pair_val) + $past(cy_in)) && gpr_r[SLOT_F][FLAG_S] == ptr_pair[15];
  endproperty
  a_adc16: assert property (p_adc16) else $error("word adc wrong"); // [RULE_08]

  property p_keep16;
    @(posedge clk) disable iff (reset)
    ex16 && kind_r == K_ADD16 |=> gpr_r[SLOT_F][FLAG_Z] ==
      $past(gpr_r[SLOT_F][FLAG_Z]) && gpr_r[SLOT_F][FLAG_C] == $past(c16);
  endproperty
  a_keep16: assert property (p_keep16) else $error("word add flags wrong"); // [RULE_11]

  property p_idx_self;
    @(posedge clk) disable iff (reset)
    ex16 && dst_r == D_IDX1 && pair_r == PAIR_SELF
      |=> idx1_r == 16'({$past(idx1_r), 1'b0});
  endproperty
  a_idx_self: assert property (p_idx_self) else $error("index self add wrong"); // [RULE_12]

endmodule : aad_datapath

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import aad_pkg::*;
  logic              clk;
  logic              reset;
  logic              ins_valid;
  logic [7:0]        ins_byte;
  logic              ins_ready;
  logic              mem_req;
  logic [WORD_W-1:0] mem_addr;
  logic              mem_ack;
  logic [7:0]        mem_rdata;
  logic              done;
  logic [1:0]        done_len;
  logic [ADDR_W-1:0] bus_addr;
  logic [7:0]        bus_wdata;
  logic              bus_wr;
  logic              bus_rd;
  logic [7:0]        bus_rdata;
  int                fail_count = 0;
  int                num_checks = 0;

  aad_datapath u_aad_datapath (.clk, .reset, .ins_valid, .ins_byte,
    .ins_ready, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .done, .done_len,
    .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata);

  // ---------------------------------------------------------------
  // Bus and instruction helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    `CHK(bus_rdata, e)
    @(posedge clk);
  endtask : rd

  task automatic send(input logic [7:0] b);
    ins_byte <= b;
    ins_valid <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      #1;
      if (ins_ready === 1'b1) break;
      @(posedge clk);
    end
    @(posedge clk);
    ins_valid <= 1'b0;
    ins_byte <= ~b;
    @(posedge clk);
  endtask : send

  task automatic mem(input logic [15:0] adr, input logic [7:0] d);
    for (int i = 0; i < 20; i++) begin
      #1;
      if (mem_req === 1'b1) break;
      @(posedge clk);
    end
    `CHK(mem_addr, adr)
    @(posedge clk);
    mem_ack <= 1'b1;
    mem_rdata <= d;
    @(posedge clk);
    mem_ack <= 1'b0;
    mem_rdata <= ~d;
  endtask : mem

  task automatic fin(input logic [1:0] len);
    for (int i = 0; i < 20; i++) begin
      #1;
      if (done === 1'b1) break;
      @(posedge clk);
    end
    `CHK(done, 1'b1)
    `CHK(done_len, len)
    @(posedge clk);
  endtask : fin

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    #1;
    `CHK({ins_ready, mem_req, done, done_len}, 5'h11)
    @(posedge clk);
    wr(4'hF, 8'h5A);
    rd(4'hF, 8'h00);
    rd(4'h7, 8'h00);
    rd(4'h6, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    logic [2:0] r;
    for (int k = 0; k < 8; k++) begin
      r = 3'(k);
      if (r != 3'h6) begin
        wr({1'b0, r}, 8'h10 + 8'(k));
        wr(4'h7, 8'h01);
        send({5'b10000, r});
        fin(2'h1);
        rd(4'h7, (r == 3'h7) ? 8'h02 : 8'h11 + 8'(k));
      end
    end
    $display("test register select done");
  endtask : t_regs

  task automatic t_add_ovf();
    wr(4'h7, 8'h7F);
    wr(4'h0, 8'h01);
    wr(4'h6, 8'h03);
    send(8'h80);
    fin(2'h1);
    rd(4'h7, 8'h80);
    rd(4'h6, 8'h94);
    $display("test add overflow done");
  endtask : t_add_ovf

  task automatic t_adc_imm();
    wr(4'h7, 8'hFF);
    wr(4'h6, 8'h01);
    send(8'hCE);
    send(8'h00);
    fin(2'h2);
    rd(4'h7, 8'h00);
    rd(4'h6, 8'h51);
    $display("test adc immediate done");
  endtask : t_adc_imm

  task automatic t_mem_ptr();
    wr(4'h4, 8'h12);
    wr(4'h5, 8'h34);
    wr(4'h7, 8'h80);
    wr(4'h6, 8'h00);
    send(8'h86);
    mem(16'h1234, 8'h80);
    fin(2'h1);
    rd(4'h7, 8'h00);
    rd(4'h6, 8'h45);
    $display("test pointer memory done");
  endtask : t_mem_ptr

  task automatic t_idx();
    wr(4'h8, 8'h10);
    wr(4'h9, 8'h00);
    wr(4'h7, 8'h0F);
    wr(4'h6, 8'h01);
    send(8'hDD);
    send(8'h8E);
    send(8'hFE);
    mem(16'h0FFE, 8'h70);
    fin(2'h3);
    rd(4'h7, 8'h80);
    rd(4'h6, 8'h94);
    $display("test indexed done");
  endtask : t_idx

  task automatic t_adc16();
    wr(4'h4, 8'h80);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h01);
    send(8'hED);
    send(8'h6A);
    fin(2'h2);
    rd(4'h4, 8'h00);
    rd(4'h5, 8'h01);
    rd(4'h6, 8'h05);
    $display("test word adc done");
  endtask : t_adc16

  task automatic t_add16();
    wr(4'h4, 8'hFF);
    wr(4'h5, 8'hFF);
    wr(4'hC, 8'h00);
    wr(4'hD, 8'h01);
    wr(4'h6, 8'hC6);
    send(8'h39);
    fin(2'h1);
    rd(4'h4, 8'h00);
    rd(4'h5, 8'h00);
    rd(4'h6, 8'hD5);
    $display("test word add done");
  endtask : t_add16

  task automatic t_addix();
    wr(4'h8, 8'h88);
    wr(4'h9, 8'h00);
    wr(4'h6, 8'hC6);
    send(8'hDD);
    send(8'h29);
    fin(2'h2);
    rd(4'h8, 8'h10);
    rd(4'h9, 8'h00);
    rd(4'h6, 8'hD5);
    $display("test index add done");
  endtask : t_addix

  task automatic t_pairs();
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h01);
    wr(4'h2, 8'h0F);
    wr(4'h3, 8'hFF);
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h00);
    send(8'h19);
    fin(2'h1);
    rd(4'h5, 8'hFF);
    send(8'hED);
    send(8'h4A);
    fin(2'h2);
    rd(4'h4, 8'h10);
    rd(4'h5, 8'h00);
    rd(4'h6, 8'h10);
    $display("test pair select done");
  endtask : t_pairs

  task automatic t_idx2();
    wr(4'hA, 8'h20);
    wr(4'hB, 8'h00);
    wr(4'h7, 8'h01);
    wr(4'h6, 8'h01);
    send(8'hFD);
    send(8'h86);
    send(8'h05);
    mem(16'h2005, 8'h01);
    fin(2'h3);
    rd(4'h7, 8'h02);
    rd(4'h6, 8'h00);
    $display("test second index done");
  endtask : t_idx2

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    ins_valid = 1'b0;
    ins_byte = 8'h00;
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_add_ovf();
    t_adc_imm();
    t_mem_ptr();
    t_idx();
    t_adc16();
    t_add16();
    t_addix();
    t_pairs();
    t_idx2();
    end_sim();
  end

  initial begin
    #(40 * 5000);
    fail_count++;
    end_sim();
  end
endmodule : testbench
